//--- src/crd_params.svh
/*
 * constants for the cluster reset controller: widths, hold times, defaults.
 * assumes inclusion by bare name from the package and the design modules.
 */
`ifndef CRD_PARAMS_SVH
`define CRD_PARAMS_SVH

`define CRD_NCPU            4
`define CRD_MIN_HOLD_CYC    16
`define CRD_CNT_W           5
`define CRD_CMD_W           4

`endif

//--- src/crd_pkg.sv
/*
 * types for the cluster reset controller: request codes and sequencer states.
 * assumes crd_params.svh is on the include path.
 */
`include "crd_params.svh"

package crd_pkg;

	// reset combinations the controller can request
	typedef enum logic [`CRD_CMD_W-1:0] {
		CRD_CMD_POR_FULL  = 4'h0,
		CRD_CMD_POR_CPU   = 4'h1,
		CRD_CMD_POR_KEEPD = 4'h2,
		CRD_CMD_SOFT_ALL  = 4'h3,
		CRD_CMD_SOFT_L2   = 4'h4,
		CRD_CMD_SOFT_CPU  = 4'h5,
		CRD_CMD_SIMD      = 4'h6,
		CRD_CMD_DBG_ALL   = 4'h7,
		CRD_CMD_DBG_CPU   = 4'h8,
		CRD_CMD_DBG_APB   = 4'h9
	} crd_cmd_t;

	typedef enum logic [1:0] {
		CRD_ST_IDLE = 2'b00,
		CRD_ST_HOLD = 2'b01,
		CRD_ST_WAIT = 2'b11
	} crd_state_t;

endpackage : crd_pkg

//--- src/crd_apb_hold.sv
/*
 * debug-apb reset hold counter, running on the debug apb clock.
 * assumes the request level is stable while held; it is synchronised here.
 */
`timescale 1ns/10ps
`include "crd_params.svh"

module crd_apb_hold #(
	parameter int unsigned MIN_HOLD = `CRD_MIN_HOLD_CYC
) (
	input  wire logic dbg_clk_i,
	input  wire logic nrst_i,
	input  wire logic req_i,
	output logic      debug_apb_reset_n_o,
	output logic      done_o
);

	logic [1:0]           sync_reg;
	logic [`CRD_CNT_W-1:0] cnt_reg;
	logic [`CRD_CNT_W-1:0] cnt_next;
	logic                 rst_n_reg;
	logic                 rst_n_next;

	always_comb
	begin
		cnt_next   = cnt_reg;
		rst_n_next = rst_n_reg;
		if (sync_reg[1])
		begin
			rst_n_next = 1'b0;
			// own counter in this domain: hold length is in apb cycles
			if (cnt_reg != `CRD_CNT_W'(MIN_HOLD))
				cnt_next = cnt_reg + `CRD_CNT_W'(1);
		end
		else
		begin
			rst_n_next = 1'b1;
			cnt_next   = '0;
		end
	end

	always_ff @(posedge dbg_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sync_reg  <= 2'b11;
			cnt_reg   <= '0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			sync_reg  <= {sync_reg[0], req_i};
			cnt_reg   <= cnt_next;
			rst_n_reg <= rst_n_next;
		end
	end

	assign debug_apb_reset_n_o = rst_n_reg;
	assign done_o = (cnt_reg == `CRD_CNT_W'(MIN_HOLD));

	a_apb_hold_len: assert property (@(posedge dbg_clk_i) disable iff (!nrst_i)
		$rose(rst_n_reg) |-> $past(cnt_reg) == `CRD_CNT_W'(MIN_HOLD))
		else $error("apb reset released early");

endmodule : crd_apb_hold

//--- src/crd_reset_ctrl.sv
/*
 * host-side reset controller for a cluster of one to four processors.
 * drives the six active-low reset groups in documented combinations.
 * assumes nrst_i is the system power-on reset; debug apb clock is separate.
 */
// Notes on behaviour
// - never assert l2 reset while cpu active
// - no apb reset while debugging, except full power-on
// - power-on always asserts power-on reset
// - soft reset: core low, por/debug high
// - full power-on asserts por, l2, apb together
// - por and l2 held 16 clocks
// - apb reset held 16 apb clocks
// - l2 released no later than cpus
// - full power-on drives every reset low, simd only when present
// - debug over power-down keeps apb high
// - simd-only reset touches only the selected simd bits
// - cluster debug reset: debug and apb low
// - run mode: every reset high
// - simd resets tied high when absent
// - core soft reset held 16 clocks
// - debug reset held 16 clocks
// - core and simd released together
`timescale 1ns/10ps
`include "crd_params.svh"

module crd_reset_ctrl #(
	parameter int unsigned NCPU     = `CRD_NCPU,
	parameter int unsigned MIN_HOLD = `CRD_MIN_HOLD_CYC,
	parameter bit          HAS_SIMD = 1'b1
) (
	input  wire logic            sys_clk_i,
	input  wire logic            nrst_i,
	input  wire logic            dbg_clk_i,
	input  wire logic            req_valid_i,
	input  wire logic [3:0]      req_cmd_i,
	input  wire logic [NCPU-1:0] req_cpu_i,
	input  wire logic [NCPU-1:0] cpu_active_i,
	input  wire logic            debug_busy_i,
	output logic                 req_ready_o,
	output logic                 done_o,
	output logic [NCPU-1:0]      cpu_poweron_reset_n_o,
	output logic [NCPU-1:0]      core_soft_reset_n_o,
	output logic [NCPU-1:0]      simd_fp_reset_n_o,
	output logic [NCPU-1:0]      core_debug_reset_n_o,
	output logic                 debug_apb_reset_n_o,
	output logic                 shared_l2_reset_n_o
);

	// one asserted-mask per reset group, applied while held
	typedef struct packed {
		logic [NCPU-1:0] por;
		logic [NCPU-1:0] core;
		logic [NCPU-1:0] simd;
		logic [NCPU-1:0] dbg;
		logic            apb;
		logic            l2;
	} crd_mask_t;

	// with no simd unit its resets stay released, even at power-on
	localparam crd_mask_t MSK_RST = '{por: '1, core: '1,
		simd: {NCPU{HAS_SIMD}}, dbg: '1, apb: 1'b1, l2: 1'b1};

	crd_pkg::crd_state_t   st_reg;
	crd_pkg::crd_state_t   st_next;
	crd_mask_t             msk_reg;
	crd_mask_t             msk_next;
	logic [`CRD_CNT_W-1:0] cnt_reg;
	logic [`CRD_CNT_W-1:0] cnt_next;
	logic                  done_reg;
	logic                  done_next;
	logic                  apb_req;
	logic                  apb_done;
	logic [1:0]            apb_done_sync_reg;
	logic                  apb_rst_n;
	logic                  legal;
	crd_mask_t             req_mask;

	function automatic crd_mask_t decode(input logic [3:0] cmd,
		input logic [NCPU-1:0] sel);
		crd_mask_t m;
		logic [NCPU-1:0] all;
		m   = '0;
		all = '1;
		unique case (crd_pkg::crd_cmd_t'(cmd))
			crd_pkg::CRD_CMD_POR_FULL:
			begin
				m = '1;
			end
			crd_pkg::CRD_CMD_POR_CPU:
			begin
				m.por = sel;
				m.core = sel;
				m.simd = sel;
				m.dbg = sel;
				m.apb = 1'b1;
			end
			crd_pkg::CRD_CMD_POR_KEEPD:
			begin
				m.por = sel;
				m.core = sel;
				m.simd = sel;
				m.dbg = sel;
				m.l2 = (sel == all);
			end
			crd_pkg::CRD_CMD_SOFT_ALL, crd_pkg::CRD_CMD_SOFT_L2:
			begin
				m.core = all;
				m.simd = all;
				m.l2 = (crd_pkg::crd_cmd_t'(cmd) == crd_pkg::CRD_CMD_SOFT_L2);
			end
			crd_pkg::CRD_CMD_SOFT_CPU:
			begin
				m.core = sel;
				m.simd = sel;
			end
			crd_pkg::CRD_CMD_SIMD:
			begin
				m.simd = sel;
			end
			crd_pkg::CRD_CMD_DBG_ALL:
			begin
				m.dbg = all;
				m.apb = 1'b1;
			end
			crd_pkg::CRD_CMD_DBG_CPU:
			begin
				m.dbg = sel;
			end
			crd_pkg::CRD_CMD_DBG_APB:
			begin
				m.apb = 1'b1;
			end
			default:
			begin
				m = '0;
			end
		endcase
		if (!HAS_SIMD)
			m.simd = '0;
		return m;
	endfunction : decode

	assign req_mask = decode(req_cmd_i, req_cpu_i);

	// refuse combinations that would break the partner's safety duties
	always_comb
	begin
		legal = (req_cmd_i <= 4'(crd_pkg::CRD_CMD_DBG_APB));
		// a cpu is still running at the edge the l2 reset would fall
		if (req_mask.l2 && (cpu_active_i != '0))
			legal = 1'b0;
		if (req_mask.apb && debug_busy_i
			&& (crd_pkg::crd_cmd_t'(req_cmd_i) != crd_pkg::CRD_CMD_POR_FULL))
			legal = 1'b0;
	end

	assign req_ready_o = (st_reg == crd_pkg::CRD_ST_IDLE);

	always_comb
	begin
		st_next   = st_reg;
		msk_next  = msk_reg;
		cnt_next  = cnt_reg;
		done_next = 1'b0;
		unique case (st_reg)
			crd_pkg::CRD_ST_IDLE:
			begin
				if (req_valid_i && legal)
				begin
					msk_next = req_mask;
					cnt_next = '0;
					st_next  = crd_pkg::CRD_ST_HOLD;
				end
			end
			crd_pkg::CRD_ST_HOLD:
			begin
				if (cnt_reg != `CRD_CNT_W'(MIN_HOLD))
					cnt_next = cnt_reg + `CRD_CNT_W'(1);
				// wait for the apb domain too: its clock may be much slower
				if (cnt_reg == `CRD_CNT_W'(MIN_HOLD)
					&& (!msk_reg.apb || apb_done_sync_reg[1]))
				begin
					// every group but apb released in one edge, l2 never after cpus
					msk_next = '0;
					st_next  = crd_pkg::CRD_ST_WAIT;
				end
			end
			crd_pkg::CRD_ST_WAIT:
			begin
				// apb side must see the release before another request
				if (apb_done_sync_reg[1] == 1'b0)
				begin
					done_next = 1'b1;
					st_next   = crd_pkg::CRD_ST_IDLE;
				end
			end
			default:
			begin
				st_next = crd_pkg::CRD_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_reg            <= crd_pkg::CRD_ST_HOLD;
			msk_reg           <= MSK_RST;
			cnt_reg           <= '0;
			done_reg          <= 1'b0;
			apb_done_sync_reg <= 2'b00;
		end
		else
		begin
			st_reg            <= st_next;
			msk_reg           <= msk_next;
			cnt_reg           <= cnt_next;
			done_reg          <= done_next;
			apb_done_sync_reg <= {apb_done_sync_reg[0], apb_done};
		end
	end

	assign apb_req = msk_reg.apb;

	crd_apb_hold #(
		.MIN_HOLD (MIN_HOLD)
	) u_apb_hold (
		.dbg_clk_i           (dbg_clk_i),
		.nrst_i              (nrst_i),
		.req_i               (apb_req),
		.debug_apb_reset_n_o (apb_rst_n),
		.done_o              (apb_done)
	);

	// low level asserts each group
	assign cpu_poweron_reset_n_o = ~msk_reg.por;
	assign core_soft_reset_n_o   = ~msk_reg.core;
	assign simd_fp_reset_n_o     = ~msk_reg.simd;
	assign core_debug_reset_n_o  = ~msk_reg.dbg;
	assign shared_l2_reset_n_o   = ~msk_reg.l2;
	assign debug_apb_reset_n_o   = apb_rst_n;
	assign done_o                = done_reg;

	a_por_hold_len: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(cpu_poweron_reset_n_o[0])
		|-> $past(cnt_reg) == `CRD_CNT_W'(MIN_HOLD))
		else $error("power-on reset released early");
	a_core_hold_len: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i)
		$rose(core_soft_reset_n_o[0])
		|-> $past(cnt_reg) == `CRD_CNT_W'(MIN_HOLD))
		else $error("core reset released early");
	a_dbg_hold_len: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(core_debug_reset_n_o[0])
		|-> $past(cnt_reg) == `CRD_CNT_W'(MIN_HOLD))
		else $error("debug reset released early");
	a_l2_not_late: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!shared_l2_reset_n_o |-> (cpu_poweron_reset_n_o == '0
		|| $stable(cpu_poweron_reset_n_o)))
		else $error("l2 reset outlived cpu reset");
	a_core_simd_pair: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i)
		$rose(core_soft_reset_n_o[0]) && !$past(simd_fp_reset_n_o[0])
		|-> simd_fp_reset_n_o[0])
		else $error("core and simd release split");
	a_soft_keeps_dbg: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i)
		st_reg == crd_pkg::CRD_ST_HOLD && msk_reg.core != '0
		&& msk_reg.por == '0 |-> core_debug_reset_n_o == '1)
		else $error("soft reset touched debug");
	a_l2_safe: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		st_reg == crd_pkg::CRD_ST_IDLE && req_valid_i && req_mask.l2
		&& cpu_active_i != '0
		|=> shared_l2_reset_n_o)
		else $error("l2 reset with active cpu");
	a_simd_tie: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!HAS_SIMD |-> ##1 simd_fp_reset_n_o == '1)
		else $error("absent simd reset driven");
	a_idle_run: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(done_o) |-> cpu_poweron_reset_n_o == '1
		&& shared_l2_reset_n_o && core_soft_reset_n_o == '1)
		else $error("not in run mode after done");

endmodule : crd_reset_ctrl

//--- testbench/crd_dev_model.sv
/*
 * behavioural model of the cluster's reset domains, seen from its pins.
 * assumes the reset groups come straight from the controller under test.
 */
`timescale 1ns/10ps

module crd_dev_model #(
	parameter int unsigned NCPU = 4
) (
	input  wire logic            sys_clk_i,
	input  wire logic            nrst_i,
	input  wire logic [NCPU-1:0] por_n_i,
	input  wire logic [NCPU-1:0] core_n_i,
	input  wire logic [NCPU-1:0] simd_n_i,
	input  wire logic [NCPU-1:0] dbg_n_i,
	input  wire logic            apb_n_i,
	input  wire logic            l2_n_i,
	input  wire logic [NCPU-1:0] cpu_active_i,
	output logic [NCPU-1:0]      core_clr_o,
	output logic [NCPU-1:0]      simd_clr_o,
	output logic [NCPU-1:0]      dbg_clr_o,
	output logic                 apb_clr_o,
	output logic                 l2_clr_o,
	output logic                 viol_o
);
	logic [NCPU-1:0] por_q;

	assign core_clr_o = ~por_n_i | ~core_n_i;
	assign simd_clr_o = core_clr_o | ~simd_n_i;
	assign dbg_clr_o  = ~por_n_i | ~dbg_n_i;
	assign apb_clr_o  = ~apb_n_i;
	assign l2_clr_o   = ~l2_n_i;

	// sticky: a wrong ordering may last a single cycle
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			por_q  <= '0;
			viol_o <= 1'b0;
		end
		else
		begin
			por_q <= por_n_i;
			if ((!l2_n_i && |cpu_active_i)
				|| (|(por_n_i & ~por_q) && !l2_n_i))
				viol_o <= 1'b1;
		end
	end
endmodule : crd_dev_model

//--- testbench/testbench.sv
/*
 * self-checking bench for the cluster reset controller.
 * assumes the design sources and crd_params.svh are compiled first.
 */
`timescale 1ns/10ps
`include "crd_params.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end

module testbench;
	logic        clk = 0, dclk = 0, nrst = 0, valid = 0, busy = 0;
	logic [3:0]  cmd = '0, sel = '0, act = '0, por, core, simd, dbg;
	logic [3:0]  cclr, sclr, dclr;
	logic        ready, done, apb, l2, aclr, lclr, viol, rdy_q, on, alow;
	logic [35:0] q[$];
	logic [35:0] nt;
	int          err_count = 0, n_compared = 0, cnt;
	wire  [16:0] outs = {por, core, simd, dbg, l2};

	initial forever #4 clk = ~clk;
	initial #3 forever #10 dclk = ~dclk;

	crd_reset_ctrl crd_reset_ctrl_inst (.sys_clk_i(clk), .nrst_i(nrst),
		.dbg_clk_i(dclk), .req_valid_i(valid), .req_cmd_i(cmd),
		.req_cpu_i(sel), .cpu_active_i(act), .debug_busy_i(busy),
		.req_ready_o(ready), .done_o(done), .cpu_poweron_reset_n_o(por),
		.core_soft_reset_n_o(core), .simd_fp_reset_n_o(simd),
		.core_debug_reset_n_o(dbg), .debug_apb_reset_n_o(apb),
		.shared_l2_reset_n_o(l2));
	crd_dev_model crd_dev_model_inst (.sys_clk_i(clk), .nrst_i(nrst),
		.por_n_i(por), .core_n_i(core), .simd_n_i(simd), .dbg_n_i(dbg),
		.apb_n_i(apb), .l2_n_i(l2), .cpu_active_i(act),
		.core_clr_o(cclr), .simd_clr_o(sclr), .dbg_clr_o(dclr),
		.apb_clr_o(aclr), .l2_clr_o(lclr), .viol_o(viol));

	// note: {apb low, soft, mask, value} of the groups while held
	function automatic logic [35:0] note(input logic [3:0] c, s);
		logic [3:0] p, k, m, d;
		logic       l;
		logic [16:0] mk;
		p = 0; k = 0; m = 0; d = 0; l = 0; mk = '1;
		case (c)
			0: begin p = 4'hF; k = 4'hF; m = 4'hF; d = 4'hF; l = 1; end
			1, 2: begin p = s; l = (c == 2) && (s == 4'hF); mk = 17'h1_E001; end
			3, 4: begin k = 4'hF; m = 4'hF; l = (c == 4); end
			5: begin k = s; m = s; end
			6: m = s;
			7: d = 4'hF;
			8: d = s;
			default: ;
		endcase
		return {(c == 0 || c == 1 || c == 7 || c == 9), (c >= 3 && c <= 6),
			mk, ~{p, k, m, d, l} & mk};
	endfunction : note

	task automatic wrap_up;
		`CHK(viol, 1'b0)
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic wait_done;
		int i;
		for (i = 0; i < 600; i++)
		begin
			@(posedge clk);
			#1;
			if (done === 1'b1)
				break;
		end
		if (i == 600)
		begin
			err_count++;
			wrap_up();
		end
		`CHK({outs, apb}, 18'h3_FFFF)
	endtask : wait_done

	task automatic req(input logic [3:0] c, s, a, input logic b, bit rf);
		cmd = c;
		sel = s;
		act = a;
		busy = b;
		if (!rf)
			q.push_back(note(c, s));
		valid = 1;
		repeat (rf ? 4 : 1) @(posedge clk);
		#1;
		valid = 0;
		if (rf)
		begin
			`CHK({ready, outs}, 18'h3_FFFF)
			// let an edge pass so valid is not raised again in this step
			@(posedge clk);
			#1;
		end
		else
			wait_done();
	endtask : req

	// watcher: hold pattern when ready falls, hold length at done
	// sampled on the falling edge, where registered outputs have settled
	always @(negedge clk)
	begin
		rdy_q <= ready;
		if (!nrst)
			on = 0;
		else if (rdy_q && !ready && q.size() > 0)
		begin
			nt = q.pop_front();
			`CHK(outs & nt[33:17], nt[16:0])
			`CHK(lclr, !nt[0])
			if (nt[34])
			begin
				`CHK(dclr, 4'h0)
				`CHK({cclr, sclr}, ~{nt[12:9], nt[12:9] & nt[8:5]})
			end
			cnt = (outs !== '1);
			alow = aclr;
			on = 1;
		end
		else if (on)
		begin
			// only cycles with a main-domain group held count
			if (outs !== '1)
				cnt++;
			if (aclr)
				alow = 1;
			if (done === 1'b1)
			begin
				`CHK(cnt >= `CRD_MIN_HOLD_CYC || &nt[16:0], 1)
				`CHK(alow, nt[35])
				on = 0;
			end
		end
	end

	initial
	begin
		int i;
		void'($urandom(99));
		repeat (3) @(posedge clk);
		#1;
		nrst = 1;
		wait_done();
		for (i = 0; i < 20; i++)
			req(i % 10, ($urandom % 15) + 1, (i % 10 == 0 || i % 10 == 4
				|| i % 10 == 2) ? 4'h0 : 4'h0 | $urandom, 0, 0);
		req(4, 4'h1, 4'h2, 0, 1);
		req(9, 4'h0, 4'h0, 1, 1);
		req(10, 4'hF, 4'h0, 0, 1);
		act = 0;
		req(5, 4'h0 | $urandom | 1, 4'h0, 0, 0);
		@(posedge clk);
		#1;
		// the model's sticky flag is cleared by the reset below
		`CHK(viol, 1'b0)
		nrst = 0;
		#2;
		`CHK({outs, apb}, 18'h0)
		repeat (3) @(posedge clk);
		#1;
		nrst = 1;
		wait_done();
		req(2, 4'hF, 4'h0, 0, 0);
		wrap_up();
	end
endmodule : testbench
